/* logic/rrb_map.svh */
`ifndef RRB_MAP_SVH
`define RRB_MAP_SVH
// How it works
// [R1] storage is a 512 by 30-bit memory, one access per 200 ns cycle
// [R2] the demultiplexer upstream delivers 20-bit data words
// [R3] input words are packed into aligned 30-bit memory words
// [R4] a full word raises a write request and copies bits 1-20 to a holding buffer
// [R5] assembly continues during a pending write; the write is served in time
// [R6] a simultaneous read and write request starts the read first
// [R7] a write drives direction low, pulses cycle initiate, then bumps write address
// [R8] a read drives direction high, pulses cycle initiate, then bumps read address
// [R9] read register, two staging buffers, word mux and 10-bit output register
// [R10] each next-word pulse outside suspension loads the output register and steps the mod-6 counter
// [R11] output words go to reconstructor or statistical decoder by mode
// [R12] counter decode empties a staging buffer, refills it, and asks for a read
// [R13] an empty memory stops unloading; staging buffers keep serving
// [R14] test generator makes eight black and white bars, each tagged 59
// [R15] after the bars come a horizontal sync word and a switch-set buffer sync word
// [R16] a repeat switch makes one or two generated lines per line
// [R17] the test generator only runs in the zero-order reduction modes
// [R18] a vertical sync word presets the sync generator to vertical blanking
// [R19] a vertical sync word clears both addresses, making the buffer empty
// [R20] unloading stops after vertical sync until blanking end is signalled
// [R21] writes continue while output is suspended
// [R22] empty when addresses match; only one memory cycle at a time
// [R23] next-word pulses during suspension are ignored
`define RRB_CLK_NS 10
`define RRB_MEM_NS 200
`define RRB_MEM_CYC ((`RRB_MEM_NS + `RRB_CLK_NS - 1) / `RRB_CLK_NS)
`define RRB_DEPTH 512
`define RRB_AW 9
`define RRB_TAG 6'h3B
`define RRB_BARS 4'h8
`define RRB_TG_LAST 3'h4
`define RRB_HSYNC_ITEM 10'h000
`define RRB_VSYNC_WORD 30'h3F00_0000
`define RRB_ADR_CTL 4'h0
`define RRB_ADR_STAT 4'h4
`define RRB_ADR_OUT 4'h8
`endif

/* logic/rrb_pkg.sv */
`include "rrb_map.svh"
package rrb_pkg;
	typedef enum logic [1:0] {RRB_ZOI, RRB_ZOP, RRB_STAT, RRB_SPARE} rrb_mode_type;
	typedef enum logic {MEM_IDLE, MEM_BUSY} rrb_mem_type;
	typedef struct packed {
		logic [9:0]   bsw;
		logic         rep;
		logic         test_en;
		rrb_mode_type mode;
	} rrb_ctl_type;
	typedef struct packed {
		logic [1:0]       ph;
		logic [19:0]      asm_r;
		logic [19:0]      hold;
		logic [9:0]       hi;
		logic             wr_pend;
		logic [29:0]      wdat;
		logic [8:0]       wa;
		logic [8:0]       ra;
		rrb_mem_type      mst;
		logic [4:0]       mcnt;
		logic             mwr;
		logic             cir;
		logic [29:0]      rreg;
		logic             rfull;
		logic [1:0][29:0] sb;
		logic [1:0]       sbf;
		logic [2:0]       cnt;
		logic [9:0]       oword;
		logic             rec_ld;
		logic             st_ld;
		logic             susp;
		logic             vs;
		logic             tg_run;
		logic             tg_second;
		logic [2:0]       tg_idx;
		logic [5:0]       tg_div;
		rrb_ctl_type      ctl;
		logic             ack;
		logic [31:0]      dat;
	} rrb_state_type;
endpackage

/* logic/rrb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rrb_map.svh"
module rrb_top #(
	parameter int DEPTH = `RRB_DEPTH
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// demultiplexer side
	input  wire logic [19:0] din_i,
	input  wire logic        din_valid_i,
	// consumer side
	input  wire logic        next_word_i,
	output logic      [9:0]  out_word_o,
	output logic             recon_load_o,
	output logic             stat_load_o,
	// sync generator side
	input  wire logic        line_start_i,
	input  wire logic        blank_end_i,
	output logic             vsync_preset_o,
	output logic             suspend_o,
	// memory cycle view
	output logic             mem_dir_o,
	output logic             cycle_initiate_request_o,
	output logic             buffer_empty_o
);
	localparam int MEM_CYC_I = `RRB_MEM_CYC;
	localparam int DONE_GAP_I = MEM_CYC_I - 8;

	if (DEPTH != (1 << `RRB_AW) || MEM_CYC_I > 32 || MEM_CYC_I < 10) begin : g_chk
		$error("rrb_top: unsupported depth or memory cycle length");
	end

	rrb_pkg::rrb_state_type s;
	rrb_pkg::rrb_state_type n;
	logic [29:0] mem [DEPTH];
	logic [29:0] mem_q;
	logic [29:0] cw;
	logic [19:0] in_w;
	logic [19:0] tg_word;
	logic [13:0] cbits;
	logic        cmp;
	logic        vs_hit;
	logic        in_v;
	logic        tg_fire;
	logic        test_act;
	logic        zero_order;
	logic        empty;
	logic        rd_req;
	logic        mem_done;
	logic        mem_start;
	logic        take;

	// bar items: sample nibble above the time tag, bars alternate black and white
	function automatic logic [9:0] tg_item(input logic [3:0] i, input logic [9:0] bsw);
		if (i < `RRB_BARS) begin
			tg_item = {(i[0] ? 4'hF : 4'h0), `RRB_TAG}; // R14
		end else if (i == `RRB_BARS) begin
			tg_item = `RRB_HSYNC_ITEM; // R15
		end else begin
			tg_item = bsw; // R15
		end
	endfunction

	function automatic logic [9:0] pick(input logic [2:0] c, input logic [1:0][29:0] sb);
		case (c)
			3'h0: pick = sb[0][9:0];
			3'h1: pick = sb[0][19:10];
			3'h2: pick = sb[0][29:20];
			3'h3: pick = sb[1][9:0];
			3'h4: pick = sb[1][19:10];
			default: pick = sb[1][29:20];
		endcase
	endfunction

	always_comb begin
		n = s;
		n.vs = 1'b0;
		n.cir = 1'b0;
		n.rec_ld = 1'b0;
		n.st_ld = 1'b0;
		cw = '0;
		cmp = 1'b0;
		cbits = s.ctl;
		zero_order = (s.ctl.mode == rrb_pkg::RRB_ZOI) || (s.ctl.mode == rrb_pkg::RRB_ZOP);
		test_act = s.ctl.test_en && zero_order; // R17
		tg_fire = s.tg_run && (s.tg_div == 6'h00);
		tg_word = {tg_item({s.tg_idx, 1'b1}, s.ctl.bsw), tg_item({s.tg_idx, 1'b0}, s.ctl.bsw)};
		in_v = test_act ? tg_fire : din_valid_i;
		in_w = test_act ? tg_word : din_i;
		empty = (s.wa == s.ra); // R22
		rd_req = !s.rfull && !empty && !s.susp; // R13 R20
		mem_done = (s.mst == rrb_pkg::MEM_BUSY) && (s.mcnt == 5'(MEM_CYC_I - 1));
		mem_q = mem[s.ra];

		// memory controller, one cycle in flight at most
		case (s.mst) // R22
			rrb_pkg::MEM_IDLE: begin
				if (rd_req) begin // R6
					n.mst = rrb_pkg::MEM_BUSY;
					n.mwr = 1'b0; // R8
					n.mcnt = 5'h00;
					n.cir = 1'b1; // R8
				end else if (s.wr_pend) begin
					n.mst = rrb_pkg::MEM_BUSY;
					n.mwr = 1'b1; // R7
					n.mcnt = 5'h00;
					n.cir = 1'b1; // R7
					n.wdat = {s.hi, s.hold};
					n.wr_pend = 1'b0;
				end
			end
			rrb_pkg::MEM_BUSY: begin
				n.mcnt = s.mcnt + 5'h01;
				if (mem_done) begin
					n.mst = rrb_pkg::MEM_IDLE;
					// direction returns high once a write has finished
					n.mwr = 1'b0; // R7
					if (s.mwr) begin
						n.wa = s.wa + 9'h001; // R7
					end else begin
						n.ra = s.ra + 9'h001; // R8
						n.rreg = mem_q;
						n.rfull = 1'b1;
					end
				end
			end
			default: n.mst = rrb_pkg::MEM_IDLE;
		endcase

		// three 20-bit inputs make two 30-bit words; bits 1-20 keep filling meanwhile
		if (in_v) begin // R21
			case (s.ph) // R3 R5
				2'h0: begin
					n.asm_r = in_w;
					n.ph = 2'h1;
				end
				2'h1: begin
					cw = {in_w[9:0], s.asm_r};
					cmp = 1'b1;
					n.asm_r = {10'h000, in_w[19:10]};
					n.ph = 2'h2;
				end
				default: begin
					cw = {in_w, s.asm_r[9:0]};
					cmp = 1'b1;
					n.ph = 2'h0;
				end
			endcase
		end
		vs_hit = cmp && (cw == `RRB_VSYNC_WORD);
		// a new word overrides the clear made at write start: set wins
		if (cmp && !vs_hit) begin
			n.wr_pend = 1'b1; // R4
			n.hold = cw[19:0]; // R4
			n.hi = cw[29:20];
		end

		// output side
		if (next_word_i && !s.susp) begin // R23
			n.oword = pick(s.cnt, s.sb); // R10
			n.cnt = (s.cnt == 3'h5) ? 3'h0 : s.cnt + 3'h1; // R10
			n.rec_ld = zero_order; // R11
			n.st_ld = (s.ctl.mode == rrb_pkg::RRB_STAT); // R11
			if (s.cnt == 3'h2) begin
				n.sbf[0] = 1'b0; // R12
			end
			if (s.cnt == 3'h5) begin
				n.sbf[1] = 1'b0; // R12
			end
		end
		// refill frees the read register, which lets a new read start
		if (s.rfull && !s.sbf[0]) begin // R9 R12
			n.sb[0] = s.rreg;
			n.sbf[0] = 1'b1;
			n.rfull = 1'b0;
		end else if (s.rfull && !s.sbf[1]) begin // R9 R12
			n.sb[1] = s.rreg;
			n.sbf[1] = 1'b1;
			n.rfull = 1'b0;
		end

		// test generator
		if (s.tg_run) begin
			n.tg_div = s.tg_div - 6'h01;
		end
		if (tg_fire) begin
			if (s.tg_idx != `RRB_TG_LAST) begin
				n.tg_idx = s.tg_idx + 3'h1;
			end else if (s.ctl.rep && !s.tg_second) begin // R16
				n.tg_idx = 3'h0;
				n.tg_second = 1'b1;
			end else begin
				n.tg_run = 1'b0;
			end
		end
		if (line_start_i && test_act && !s.tg_run) begin // R16
			n.tg_run = 1'b1;
			n.tg_idx = 3'h0;
			n.tg_second = 1'b0;
			n.tg_div = 6'h00;
		end
		if (!test_act) begin
			n.tg_run = 1'b0; // R17
		end

		// suspension: blanking end clears, a fresh vertical sync wins
		if (blank_end_i) begin
			n.susp = 1'b0; // R20
		end
		if (vs_hit) begin
			n.wa = 9'h000; // R19
			n.ra = 9'h000; // R19
			n.susp = 1'b1; // R20
			n.vs = 1'b1; // R18
			n.ph = 2'h0; // R3
		end

		// wishbone: every access answered one cycle later, unmapped reads zero
		take = wb_cyc_i && wb_stb_i && !s.ack;
		n.ack = take;
		if (take) begin
			n.dat = 32'h0000_0000;
			if (wb_we_i && (wb_adr_i == `RRB_ADR_CTL)) begin
				if (wb_sel_i[0]) begin
					cbits[7:0] = wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					cbits[13:8] = wb_dat_i[13:8];
				end
				n.ctl = rrb_pkg::rrb_ctl_type'(cbits);
			end else if (!wb_we_i) begin
				case (wb_adr_i)
					`RRB_ADR_CTL: n.dat = {18'h00000, cbits};
					`RRB_ADR_STAT: n.dat = {12'h000, s.susp, empty, s.ra, s.wa};
					`RRB_ADR_OUT: n.dat = {22'h000000, s.oword};
					default: n.dat = 32'h0000_0000;
				endcase
			end
		end
		mem_start = (s.mst == rrb_pkg::MEM_IDLE) && (n.mst == rrb_pkg::MEM_BUSY);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// memory array has no reset; contents are valid only once written
	always_ff @(posedge clk_i) begin
		if (!rst_i && mem_done && s.mwr) begin
			mem[s.wa] <= s.wdat; // R1
		end
	end

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign out_word_o = s.oword;
	assign recon_load_o = s.rec_ld;
	assign stat_load_o = s.st_ld;
	assign vsync_preset_o = s.vs;
	assign suspend_o = s.susp;
	assign mem_dir_o = !s.mwr;
	assign cycle_initiate_request_o = s.cir;
	assign buffer_empty_o = empty;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_quiet;
		!mem_done [*8];
	endsequence
	sequence s_busy;
		(s.mst == rrb_pkg::MEM_BUSY) [*8];
	endsequence

	a_cycle_length: assert property (mem_start |=> s_quiet ##DONE_GAP_I mem_done) // R1
		else $error("memory cycle length wrong");
	a_single_cycle: assert property (mem_start |=> s_busy ##0 !cycle_initiate_request_o) // R22
		else $error("second memory cycle started early");
	a_read_first: assert property (
		(s.mst == rrb_pkg::MEM_IDLE && rd_req && s.wr_pend) |=> (s.cir && !s.mwr)) // R6
		else $error("write taken before read");
	a_write_addr: assert property ((mem_done && s.mwr && !vs_hit) |=> // R7
		(s.wa == $past(s.wa) + 9'h001) && mem_dir_o)
		else $error("write address not advanced");
	a_read_addr: assert property ((mem_done && !s.mwr && !vs_hit) |=> // R8
		(s.ra == $past(s.ra) + 9'h001) && s.rfull)
		else $error("read address not advanced");
	a_dir_steady: assert property ((s.mst == rrb_pkg::MEM_BUSY) |-> (mem_dir_o == !s.mwr)) // R7
		else $error("direction line wrong during cycle");
	a_out_load: assert property ((next_word_i && !s.susp) |=> // R10
		(s.oword == pick($past(s.cnt), $past(s.sb))) && (s.rec_ld || s.st_ld || !zero_order))
		else $error("output word not loaded");
	a_count_mod: assert property ((next_word_i && !s.susp && s.cnt == 3'h5) |=> s.cnt == 3'h0) // R10
		else $error("mod-6 counter wrong");
	a_ignore_susp: assert property ((next_word_i && s.susp) |=> $stable(s.cnt) && !s.rec_ld) // R23
		else $error("next word taken while suspended");
	a_vs_clear: assert property (vs_hit |=> (s.wa == 9'h000) && (s.ra == 9'h000) // R19
		&& s.susp && vsync_preset_o)
		else $error("vertical sync did not clear buffer");
	a_no_unload: assert property (s.susp |-> !(mem_start && !n.mwr)) // R20
		else $error("read started while suspended");
	a_hold_copy: assert property ((cmp && !vs_hit) |=> s.wr_pend && (s.hold == $past(cw[19:0]))) // R4
		else $error("holding buffer not loaded");
	a_refill: assert property ((s.rfull && !s.sbf[0]) |=> s.sbf[0] && (s.sb[0] == $past(s.rreg))) // R12
		else $error("staging buffer not refilled");
endmodule // rrb_top
`default_nettype wire

/* bench/rrb_consumer.sv */
`timescale 1ns/1ns
`default_nettype none
module rrb_consumer (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// bench control
	input  wire logic       start_i,
	input  wire logic [3:0] n_i,
	input  wire logic [3:0] gap_i,
	// toward the block
	output logic            next_word_o,
	output logic            busy_o
);
	logic [3:0] left;
	logic [3:0] wait_c;
	assign busy_o = (left != 4'h0);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left <= 4'h0;
			wait_c <= 4'h0;
			next_word_o <= 1'b0;
		end else if (start_i) begin
			left <= n_i;
			wait_c <= 4'h0;
			next_word_o <= 1'b0;
		end else if (left != 4'h0 && wait_c == 4'h0 && !next_word_o) begin
			// one-cycle pulse per word; a held level would count as many words
			next_word_o <= 1'b1;
			left <= left - 4'h1;
			wait_c <= gap_i;
		end else begin
			next_word_o <= 1'b0;
			if (wait_c != 4'h0) wait_c <= wait_c - 4'h1;
		end
	end
endmodule // rrb_consumer
`default_nettype wire

/* bench/rrb_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
module rrb_top_test;
	logic        clk_i, rst_i, cyc, stb, we, dv, nw, blank, start, busy, ls;
	logic [3:0]  adr, cn, cg;
	logic [31:0] wdat, rdat, q;
	logic [19:0] din;
	logic [9:0]  ow;
	logic        ack, rld, sld, vsp, susp, dir, cir, emp;
	logic [59:0] s;
	logic [11:0] seen[$];
	int          n_errors = 0;
	int          checked = 0;
	rrb_top i_rrb_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .din_i(din), .din_valid_i(dv), .next_word_i(nw), .out_word_o(ow),
		.recon_load_o(rld), .stat_load_o(sld), .line_start_i(ls), .blank_end_i(blank),
		.vsync_preset_o(vsp), .suspend_o(susp), .mem_dir_o(dir),
		.cycle_initiate_request_o(cir), .buffer_empty_o(emp));
	rrb_consumer i_rrb_consumer (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .n_i(cn),
		.gap_i(cg), .next_word_o(nw), .busy_o(busy));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (rld === 1'b1 || sld === 1'b1) seen.push_back({rld, sld, ow});
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
		chk("ack", 32'h1, {31'h0, ack});
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic put(input logic [19:0] w);
		@(posedge clk_i);
		din <= w;
		dv <= 1'b1;
		@(posedge clk_i);
		dv <= 1'b0;
	endtask
	// wait for the next memory cycle start and report its direction
	task automatic waitc(input string what, input logic e);
		int k;
		k = 0;
		do begin @(posedge clk_i); k++; end while (cir !== 1'b1 && k < 40);
		chk("cycle start", 32'h1, {31'h0, cir});
		chk(what, {31'h0, e}, {31'h0, dir});
	endtask
	task automatic ask(input logic [3:0] n, input logic [3:0] g);
		int k;
		@(posedge clk_i);
		cn <= n;
		cg <= g;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		k = 0;
		do begin @(posedge clk_i); k++; end while (busy !== 1'b0 && k < 100);
		chk("consumer done", 32'h0, {31'h0, busy});
		repeat (4) @(posedge clk_i);
	endtask
	task automatic t_regs();
		chk("idle outputs", 32'h3, {15'h0, ow, rld, sld, vsp, susp, cir, dir, emp});
		bus(1'b1, `RRB_ADR_CTL, 32'h0000_3FFA);
		bus(1'b0, `RRB_ADR_CTL, 32'h0);
		chk("ctl", 32'h0000_3FFA, q);
		bus(1'b1, `RRB_ADR_STAT, 32'hFFFF_FFFF);
		bus(1'b0, `RRB_ADR_STAT, 32'h0);
		chk("stat", 32'h0004_0000, q);
		bus(1'b0, 4'hC, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b1, `RRB_ADR_CTL, 32'h0);
	endtask
	task automatic t_fill();
		s = 60'h5A5A5_ABCDE_12345;
		put(s[19:0]);
		repeat (12) @(posedge clk_i);
		put(s[39:20]);
		waitc("write dir", 1'b0);
		waitc("read dir", 1'b1);
		put(s[59:40]);
		repeat (80) @(posedge clk_i);
		bus(1'b0, `RRB_ADR_STAT, 32'h0);
		chk("stat", 32'h0004_0402, q);
	endtask
	task automatic t_unload();
		ask(4'h3, 4'h3);
		bus(1'b1, `RRB_ADR_CTL, 32'h2);
		ask(4'h3, 4'h0);
		chk("words", 32'd6, seen.size());
		for (int i = 0; i < 6; i++) begin
			chk("word", {20'h0, (i < 3) ? 2'b10 : 2'b01, s[i*10 +: 10]}, {20'h0, seen[i]});
		end
		bus(1'b1, `RRB_ADR_CTL, 32'h0);
	endtask
	task automatic t_vsync();
		int k;
		put(20'h0);
		repeat (12) @(posedge clk_i);
		put(20'h003F0);
		k = 0;
		do begin @(posedge clk_i); k++; end while (vsp !== 1'b1 && k < 10);
		chk("vsync", 32'h7, {29'h0, vsp, susp, emp});
		k = seen.size();
		ask(4'h2, 4'h1);
		chk("ignored", k, seen.size());
		put(20'h11111);
		repeat (12) @(posedge clk_i);
		put(20'h22222);
		waitc("write dir", 1'b0);
		@(posedge clk_i);
		blank <= 1'b1;
		@(posedge clk_i);
		blank <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("suspend", 32'h0, {31'h0, susp});
	endtask
	// zero-order mode, test on, repeat on: ten generated words from phase 2 give
	// seven writes; two reads fill the free staging buffer and the read register
	task automatic t_tgen();
		bus(1'b1, `RRB_ADR_CTL, 32'h0000_2A5C);
		@(posedge clk_i);
		ls <= 1'b1;
		@(posedge clk_i);
		ls <= 1'b0;
		repeat (700) @(posedge clk_i);
		bus(1'b0, `RRB_ADR_STAT, 32'h0);
		chk("test writes", 32'h0000_0608, q);
		bus(1'b1, `RRB_ADR_CTL, 32'h0);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		{cyc, stb, we, dv, blank, start, ls} = 7'h00;
		{adr, cn, cg, wdat, din} = '0;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_fill();
		t_unload();
		t_vsync();
		t_tgen();
		wrap_up();
	end
	// the sequence needs about 1000 cycles; ten thousand means a hang
	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end
endmodule // rrb_top_test
`default_nettype wire
